//--- macmh_pkg.sv
// Constants and types for the multicast filter and MAC configuration block
package macmh_pkg;

	// ----------------------------------------------------------------
	// Register map (byte offsets on the I/O register port)
	// ----------------------------------------------------------------
	localparam int unsigned ADDR_W          = 8;
	localparam logic [7:0]  OFS_MAC_CONFIG  = 8'h50;
	localparam logic [7:0]  OFS_FILTER_W0   = 8'h60;
	localparam logic [7:0]  OFS_FILTER_W1   = 8'h62;
	localparam logic [7:0]  OFS_FILTER_W2   = 8'h64;
	localparam logic [7:0]  OFS_FILTER_W3   = 8'h66;
	localparam int unsigned FILTER_WORDS    = 4;
	localparam int unsigned FILTER_WORD_W   = 16;

	// ----------------------------------------------------------------
	// mac_config fields and reset value
	// ----------------------------------------------------------------
	localparam logic [31:0] MAC_CONFIG_RST  = 32'h0000_0000;
	localparam logic [31:0] MAC_CONFIG_MASK = 32'h0000_0323;
	localparam int unsigned GAP_LSB         = 0;
	localparam int unsigned GAP_W           = 2;
	localparam int unsigned DUPLEX_BIT      = 5;
	localparam int unsigned PAUSE_BIT       = 8;
	localparam int unsigned BIG_FRAME_BIT   = 9;
	localparam logic [15:0] FILTER_RST      = 16'h0000;

	// ----------------------------------------------------------------
	// Inter-frame gap in bit times
	// ----------------------------------------------------------------
	localparam logic [9:0]  IFS_BT_0        = 10'h060;
	localparam logic [9:0]  IFS_BT_1        = 10'h080;
	localparam logic [9:0]  IFS_BT_2        = 10'h0E0;
	localparam logic [9:0]  IFS_BT_3        = 10'h220;

	// ----------------------------------------------------------------
	// Frame sizes and layout (byte indices from the first DA byte)
	// ----------------------------------------------------------------
	localparam logic [15:0] LEN_LIMIT_STD   = 16'h05EA;
	localparam logic [15:0] LEN_LIMIT_BIG   = 16'h118B;
	localparam logic [15:0] LEN_MAX         = 16'hFFFF;
	localparam logic [15:0] DA_LAST_IDX     = 16'h0005;
	localparam logic [15:0] CTRL_FIRST_IDX  = 16'h000C;
	localparam logic [15:0] CTRL_LAST_IDX   = 16'h000F;
	localparam logic [15:0] QUANTA_HI_IDX   = 16'h0010;
	localparam logic [15:0] QUANTA_LO_IDX   = 16'h0011;
	localparam int unsigned INDEX_W         = 6;

	// ----------------------------------------------------------------
	// PAUSE frame signature
	// ----------------------------------------------------------------
	localparam logic [47:0] PAUSE_DA        = 48'h0180_C200_0001;
	localparam logic [31:0] PAUSE_TYPE_OP   = 32'h8808_0001;

	// ----------------------------------------------------------------
	// Frame check CRC (reflected form)
	// ----------------------------------------------------------------
	localparam logic [31:0] CRC_POLY        = 32'hEDB8_8320;
	localparam logic [31:0] CRC_INIT        = 32'hFFFF_FFFF;

	// ----------------------------------------------------------------
	// Receive reset sequencer
	// ----------------------------------------------------------------
	localparam int unsigned RX_RST_CYCLES   = 16;

	typedef enum logic [1:0] {
		MACMH_RS_IDLE = 2'b01,
		MACMH_RS_BUSY = 2'b10
	} macmh_rst_state_t;

endpackage : macmh_pkg

//--- macmh_crc_if.sv
// Carrier between the receive parser and the destination address CRC
`timescale 1ns/100ps
interface macmh_crc_if;
	logic        init;
	logic        valid;
	logic [7:0]  data;
	logic [31:0] crc;

	modport parser (output init, output valid, output data, input crc);
	modport engine (input init, input valid, input data, output crc);
endinterface : macmh_crc_if

//--- macmh_crc.sv
// Byte-wide frame check CRC engine used over the destination address
`timescale 1ns/100ps
module macmh_crc (
	input  wire logic   sys_clk,
	input  wire logic   arst_n,
	macmh_crc_if.engine crc_port
);

	logic [31:0] crc_r;
	logic [31:0] crc_nxt;

	// ----------------------------------------------------------------
	// Next value: init restarts from all ones so no stale frame leaks
	// ----------------------------------------------------------------
	always_comb begin
		crc_nxt = crc_port.init ? macmh_pkg::CRC_INIT : crc_r;
		for (int i = 0; i < 8; i++) begin
			if (crc_nxt[0] ^ crc_port.data[i]) begin
				crc_nxt = (crc_nxt >> 1) ^ macmh_pkg::CRC_POLY;
			end else begin
				crc_nxt = crc_nxt >> 1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			crc_r <= macmh_pkg::CRC_INIT;
		end else if (crc_port.valid) begin
			crc_r <= crc_nxt;
		end
	end

	assign crc_port.crc = crc_r;

endmodule : macmh_crc

//--- macmh_top.sv
// Multicast hash filter and MAC configuration register
`timescale 1ns/100ps
module macmh_top #(
	parameter int unsigned RST_CYCLES = macmh_pkg::RX_RST_CYCLES
) (
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	input  wire logic [7:0]  io_addr,
	input  wire logic        io_wr,
	input  wire logic        io_rd,
	input  wire logic [3:0]  io_be,
	input  wire logic [31:0] io_wdata,
	output logic      [31:0] io_rdata,
	input  wire logic        group_filter_enable,
	input  wire logic        other_accept,
	input  wire logic        rx_valid,
	input  wire logic        rx_sof,
	input  wire logic        rx_eof,
	input  wire logic [7:0]  rx_data,
	input  wire logic        rx_fcs_ok,
	input  wire logic        carrier_sense,
	input  wire logic        carrier_sense_err,
	input  wire logic        receive_path_reset,
	input  wire logic        reset_sel_net,
	input  wire logic        reset_sel_fifo,
	input  wire logic        reset_sel_dma,
	output logic             rx_net_reset,
	output logic             rx_fifo_reset,
	output logic             rx_dma_reset,
	output logic             rx_reset_busy,
	output logic             filter_done,
	output logic             filter_accept,
	output logic             filter_multicast,
	output logic             frame_too_long_error,
	output logic             pause_req,
	output logic      [15:0] pause_quanta,
	output logic             tx_defer,
	output logic             carrier_loss_count_en,
	output logic      [9:0]  ifs_bit_times,
	output logic             duplex_both_ways,
	output logic             pause_handling_on,
	output logic             big_frame_limit
);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [31:0] mac_config_r;
	logic [15:0] filter_word_r [macmh_pkg::FILTER_WORDS];
	logic [63:0] multicast_filter_table;
	logic [1:0]  gap_select;
	logic [1:0]  word_sel;
	logic        word_hit;
	logic        cfg_hit;
	always_comb begin
		cfg_hit  = 1'b0;
		word_hit = 1'b0;
		word_sel = 2'b00;
		if (io_addr == macmh_pkg::OFS_MAC_CONFIG) begin
			cfg_hit = 1'b1;
		end else if (io_addr == macmh_pkg::OFS_FILTER_W0) begin
			word_hit = 1'b1;
			word_sel = 2'b00;
		end else if (io_addr == macmh_pkg::OFS_FILTER_W1) begin
			word_hit = 1'b1;
			word_sel = 2'b01;
		end else if (io_addr == macmh_pkg::OFS_FILTER_W2) begin
			word_hit = 1'b1;
			word_sel = 2'b10;
		end else if (io_addr == macmh_pkg::OFS_FILTER_W3) begin
			word_hit = 1'b1;
			word_sel = 2'b11;
		end
	end
	// Reserved bits never store, so they always read back as zero
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			mac_config_r <= macmh_pkg::MAC_CONFIG_RST;
		end else if (io_wr && cfg_hit) begin
			for (int b = 0; b < 4; b++) begin
				if (io_be[b]) begin
					mac_config_r[8*b +: 8] <= io_wdata[8*b +: 8]
						& macmh_pkg::MAC_CONFIG_MASK[8*b +: 8];
				end
			end
		end
	end
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int w = 0; w < macmh_pkg::FILTER_WORDS; w++) begin
				filter_word_r[w] <= macmh_pkg::FILTER_RST;
			end
		end else if (io_wr && word_hit) begin
			if (io_be[0]) begin
				filter_word_r[word_sel][7:0] <= io_wdata[7:0];
			end
			if (io_be[1]) begin
				filter_word_r[word_sel][15:8] <= io_wdata[15:8];
			end
		end
	end
	// Word 3 holds the top bits, word 0 the bottom ones
	assign multicast_filter_table = {filter_word_r[3], filter_word_r[2],
		filter_word_r[1], filter_word_r[0]};
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			io_rdata <= 32'h0000_0000;
		end else if (io_rd) begin
			if (cfg_hit) begin
				io_rdata <= mac_config_r;
			end else if (word_hit) begin
				io_rdata <= {16'h0000, filter_word_r[word_sel]};
			end else begin
				io_rdata <= 32'h0000_0000;
			end
		end
	end

	// ----------------------------------------------------------------
	// Configuration outputs
	// ----------------------------------------------------------------
	assign gap_select        = mac_config_r[macmh_pkg::GAP_LSB +:
		macmh_pkg::GAP_W];
	assign duplex_both_ways  = mac_config_r[macmh_pkg::DUPLEX_BIT];
	assign pause_handling_on = mac_config_r[macmh_pkg::PAUSE_BIT];
	assign big_frame_limit   = mac_config_r[macmh_pkg::BIG_FRAME_BIT];
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ifs_bit_times <= macmh_pkg::IFS_BT_0;
		end else begin
			case (gap_select)
				2'b00: ifs_bit_times <= macmh_pkg::IFS_BT_0;
				2'b01: ifs_bit_times <= macmh_pkg::IFS_BT_1;
				2'b10: ifs_bit_times <= macmh_pkg::IFS_BT_2;
				default: ifs_bit_times <= macmh_pkg::IFS_BT_3;
			endcase
		end
	end
	// Duplex changes take hold at once; the host must reset both paths
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_defer              <= 1'b0;
			carrier_loss_count_en <= 1'b0;
		end else begin
			tx_defer <= carrier_sense & ~duplex_both_ways;
			carrier_loss_count_en <= carrier_sense_err
				& ~duplex_both_ways;
		end
	end

	// ----------------------------------------------------------------
	// Receive path reset sequencer
	// ----------------------------------------------------------------
	macmh_pkg::macmh_rst_state_t rst_state_r;
	logic [7:0]  rst_cnt_r;
	logic [2:0]  rst_sel_r;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_state_r <= macmh_pkg::MACMH_RS_IDLE;
			rst_cnt_r   <= 8'h00;
			rst_sel_r   <= 3'b000;
		end else begin
			case (rst_state_r)
				macmh_pkg::MACMH_RS_IDLE: begin
					if (receive_path_reset) begin
						rst_state_r <= macmh_pkg::MACMH_RS_BUSY;
						rst_cnt_r   <= 8'(RST_CYCLES - 1);
						rst_sel_r   <= {reset_sel_dma, reset_sel_fifo,
							reset_sel_net};
					end
				end
				macmh_pkg::MACMH_RS_BUSY: begin
					if (rst_cnt_r == 8'h00) begin
						rst_state_r <= macmh_pkg::MACMH_RS_IDLE;
						rst_sel_r   <= 3'b000;
					end else begin
						rst_cnt_r <= rst_cnt_r - 8'h01;
					end
				end
				default: rst_state_r <= macmh_pkg::MACMH_RS_IDLE;
			endcase
		end
	end

	assign rx_reset_busy = (rst_state_r == macmh_pkg::MACMH_RS_BUSY);
	assign rx_net_reset  = rst_sel_r[0];
	assign rx_fifo_reset = rst_sel_r[1];
	assign rx_dma_reset  = rst_sel_r[2];
	// ----------------------------------------------------------------
	// Receive parser
	// ----------------------------------------------------------------
	macmh_crc_if crc_link ();

	macmh_crc u_crc (
		.sys_clk  (sys_clk),
		.arst_n   (arst_n),
		.crc_port (crc_link.engine)
	);
	logic [15:0] idx_cur;
	logic [15:0] byte_cnt_r;
	logic [15:0] len_cur;
	logic [15:0] len_limit;
	logic        mc_r;
	logic        da_done_r;
	logic        sig_ok_r;
	logic        sig_ok_cur;
	logic [7:0]  sig_byte;
	logic        sig_check;
	logic [15:0] quanta_r;
	logic [5:0]  hash_index;

	assign idx_cur = rx_sof ? 16'h0000 : byte_cnt_r;
	assign len_cur = (idx_cur == macmh_pkg::LEN_MAX) ? idx_cur
		: idx_cur + 16'h0001;
	assign len_limit = big_frame_limit ? macmh_pkg::LEN_LIMIT_BIG
		: macmh_pkg::LEN_LIMIT_STD;
	assign crc_link.init  = rx_valid & rx_sof;
	assign crc_link.valid = rx_valid
		& (idx_cur <= macmh_pkg::DA_LAST_IDX);
	assign crc_link.data  = rx_data;
	assign hash_index     = crc_link.crc[macmh_pkg::INDEX_W-1:0];
	// Expected PAUSE byte at this position; other positions are not checked
	always_comb begin
		sig_byte  = 8'h00;
		sig_check = 1'b0;
		if (idx_cur <= macmh_pkg::DA_LAST_IDX) begin
			sig_byte  = macmh_pkg::PAUSE_DA[8*(5 - idx_cur[2:0]) +: 8];
			sig_check = 1'b1;
		end else if (idx_cur >= macmh_pkg::CTRL_FIRST_IDX &&
			idx_cur <= macmh_pkg::CTRL_LAST_IDX) begin
			sig_byte  = macmh_pkg::PAUSE_TYPE_OP[8*(3 - idx_cur[1:0])
				+: 8];
			sig_check = 1'b1;
		end
	end

	assign sig_ok_cur = (rx_sof | sig_ok_r)
		& (~sig_check | (rx_data == sig_byte));
	// A network reset drops any frame in flight
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			byte_cnt_r <= 16'h0000;
			mc_r       <= 1'b0;
			da_done_r  <= 1'b0;
			sig_ok_r   <= 1'b0;
			quanta_r   <= 16'h0000;
		end else if (rx_net_reset) begin
			byte_cnt_r <= 16'h0000;
			mc_r       <= 1'b0;
			da_done_r  <= 1'b0;
			sig_ok_r   <= 1'b0;
		end else begin
			da_done_r <= rx_valid & (idx_cur == macmh_pkg::DA_LAST_IDX);
			if (rx_valid) begin
				byte_cnt_r <= len_cur;
				sig_ok_r   <= sig_ok_cur;
				if (rx_sof) begin
					mc_r <= rx_data[0];
				end
				if (idx_cur == macmh_pkg::QUANTA_HI_IDX) begin
					quanta_r[15:8] <= rx_data;
				end
				if (idx_cur == macmh_pkg::QUANTA_LO_IDX) begin
					quanta_r[7:0] <= rx_data;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Filter decision, two cycles after the last address byte
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			filter_done      <= 1'b0;
			filter_accept    <= 1'b0;
			filter_multicast <= 1'b0;
		end else begin
			filter_done <= da_done_r & ~rx_net_reset;
			if (da_done_r) begin
				filter_multicast <= mc_r;
				if (!mc_r) begin
					filter_accept <= other_accept;
				end else if (group_filter_enable) begin
					filter_accept <=
						multicast_filter_table[hash_index];
				end else begin
					filter_accept <= other_accept;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// End of frame: oversize and PAUSE detection
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			frame_too_long_error <= 1'b0;
			pause_req            <= 1'b0;
			pause_quanta         <= 16'h0000;
		end else begin
			frame_too_long_error <= rx_valid & rx_eof & ~rx_net_reset
				& (len_cur >= len_limit);
			// With pause handling off a PAUSE frame stays plain data
			pause_req <= rx_valid & rx_eof & ~rx_net_reset
				& pause_handling_on & sig_ok_cur & rx_fcs_ok
				& (idx_cur > macmh_pkg::QUANTA_LO_IDX);
			if (rx_valid && rx_eof && pause_handling_on && sig_ok_cur) begin
				pause_quanta <= quanta_r;
			end
		end
	end

endmodule : macmh_top

//--- macmh_props.sv
// Concurrent checks on the filter and configuration block ports
`timescale 1ns/100ps
module macmh_props #(
	parameter int unsigned RST_CYCLES = 16
) (
	input wire logic        sys_clk,
	input wire logic        arst_n,
	input wire logic [7:0]  io_addr,
	input wire logic        io_wr,
	input wire logic        io_rd,
	input wire logic [3:0]  io_be,
	input wire logic [31:0] io_wdata,
	input wire logic [31:0] io_rdata,
	input wire logic        group_filter_enable,
	input wire logic        other_accept,
	input wire logic        carrier_sense,
	input wire logic        receive_path_reset,
	input wire logic        reset_sel_net,
	input wire logic        rx_net_reset,
	input wire logic        rx_reset_busy,
	input wire logic        filter_done,
	input wire logic        filter_accept,
	input wire logic        filter_multicast,
	input wire logic        frame_too_long_error,
	input wire logic        pause_req,
	input wire logic        tx_defer,
	input wire logic        carrier_loss_count_en,
	input wire logic [9:0]  ifs_bit_times,
	input wire logic        duplex_both_ways,
	input wire logic        pause_handling_on,
	input wire logic        big_frame_limit
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// ----------------------------------------------------------------
	// Helper logic
	// ----------------------------------------------------------------
	// Counting busy cycles keeps the length check free of long repeats
	logic [15:0] busy_cnt_r;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			busy_cnt_r <= 16'h0000;
		else if (rx_reset_busy)
			busy_cnt_r <= busy_cnt_r + 16'h0001;
		else
			busy_cnt_r <= 16'h0000;
	end
	sequence s_cmd;
		receive_path_reset && !rx_reset_busy;
	endsequence
	sequence s_cfg_wr;
		io_wr && io_addr == macmh_pkg::OFS_MAC_CONFIG;
	endsequence
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_rst_start: assert property (s_cmd |=> rx_reset_busy &&
		rx_net_reset == $past(reset_sel_net)) else $error("reset start");
	a_rst_length: assert property ($fell(rx_reset_busy) |->
		busy_cnt_r == 16'(RST_CYCLES)) else $error("reset length");
	a_gap_wide: assert property (s_cfg_wr ##0 (io_be[0] &&
		io_wdata[1:0] == 2'b11) |=> ##1 ifs_bit_times == 10'h220)
		else $error("gap value");
	a_cfg_bits: assert property (s_cfg_wr ##0 io_be[1] |=>
		pause_handling_on == $past(io_wdata[8]) &&
		big_frame_limit == $past(io_wdata[9])) else $error("config bits");
	a_duplex_mask: assert property (duplex_both_ways |=>
		!tx_defer && !carrier_loss_count_en) else $error("duplex mask");
	a_half_defer: assert property (!duplex_both_ways &&
		carrier_sense |=> tx_defer) else $error("no defer");
	a_unmapped_rd: assert property (io_rd && io_addr == 8'h70 |=>
		io_rdata == 32'h0000_0000) else $error("unmapped read");
	a_table_hi: assert property (io_rd && io_addr[7:4] == 4'h6 |=>
		io_rdata[31:16] == 16'h0000) else $error("table upper bits");
	a_bypass_acc: assert property (filter_done && (!filter_multicast
		|| !group_filter_enable) |-> filter_accept == other_accept)
		else $error("bypass accept");
	a_done_pulse: assert property (filter_done |=> !filter_done)
		else $error("decision pulse");
	a_long_pulse: assert property (frame_too_long_error |=>
		!frame_too_long_error) else $error("oversize pulse");
	a_pause_gate: assert property (pause_req |-> pause_handling_on)
		else $error("pause while off");
endmodule : macmh_props
bind macmh_top macmh_props #(.RST_CYCLES(RST_CYCLES)) i_props (.*);

//--- macmh_phy_model.sv
// Receive byte source standing in for the PHY side of the filter
`timescale 1ns/100ps
module macmh_phy_model (
	input  wire logic       sys_clk,
	output logic            rx_valid,
	output logic            rx_sof,
	output logic            rx_eof,
	output logic      [7:0] rx_data,
	output logic            rx_fcs_ok
);
	initial begin
		rx_valid  = 1'b0;
		rx_sof    = 1'b0;
		rx_eof    = 1'b0;
		rx_data   = 8'h00;
		rx_fcs_ok = 1'b0;
	end
	// Idle data is the inverse of the last byte so stale values never match
	task automatic send(input logic [7:0] b [$], input int gap);
		for (int i = 0; i < b.size(); i++) begin
			@(posedge sys_clk);
			rx_valid  <= 1'b1;
			rx_sof    <= (i == 0);
			rx_eof    <= (i == b.size() - 1);
			rx_data   <= b[i];
			rx_fcs_ok <= (i == b.size() - 1);
			repeat (gap) begin
				@(posedge sys_clk);
				rx_valid <= 1'b0;
				rx_data  <= ~b[i];
			end
		end
		@(posedge sys_clk);
		rx_valid  <= 1'b0;
		rx_eof    <= 1'b0;
		rx_fcs_ok <= 1'b0;
		rx_data   <= ~b[b.size() - 1];
	endtask : send
endmodule : macmh_phy_model

//--- tb.sv
// Self-checking bench for the multicast filter and MAC configuration
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
	n_mismatch++; $display("ERROR t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb;
	logic [7:0]  io_addr, rx_data;
	logic [3:0]  io_be;
	logic [31:0] io_wdata, io_rdata, rng, d;
	logic [15:0] pause_quanta;
	logic [9:0]  ifs_bit_times;
	logic        sys_clk, arst_n, io_wr, io_rd, rx_valid, rx_sof, rx_eof;
	logic        rx_fcs_ok, carrier_sense, carrier_sense_err, rx_net_reset;
	logic        receive_path_reset, reset_sel_net, reset_sel_fifo;
	logic        reset_sel_dma, rx_fifo_reset, rx_dma_reset, rx_reset_busy;
	logic        filter_done, filter_accept, filter_multicast, pause_req;
	logic        frame_too_long_error, tx_defer, carrier_loss_count_en;
	logic        duplex_both_ways, pause_handling_on, big_frame_limit;
	logic        group_filter_enable, other_accept, pause_on, big_on;
	logic [1:0]  mon_e;
	logic [63:0] tbl;
	logic [47:0] da;
	logic [7:0]  fr [$];
	logic [1:0]  exp_acc [$];
	int          n_mismatch, samples_checked, long_seen, pause_seen;
	int          long_exp, pause_exp;
	localparam logic [9:0] GTAB [4] = '{10'h060, 10'h080, 10'h0E0, 10'h220};
	macmh_top #(.RST_CYCLES(2)) i_dut (.*);
	macmh_phy_model i_phy (.*);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : xs
	// Bench's own CRC, no final inversion, first DA byte first
	function automatic logic [5:0] hidx(input logic [47:0] a);
		logic [31:0] c;
		c = macmh_pkg::CRC_INIT;
		for (int i = 5; i >= 0; i--) begin
			c ^= {24'h000000, a[i*8 +: 8]};
			for (int k = 0; k < 8; k++)
				c = c[0] ? (c >> 1) ^ macmh_pkg::CRC_POLY : c >> 1;
		end
		return c[5:0];
	endfunction : hidx
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
			input logic [3:0] be);
		@(posedge sys_clk);
		io_wr    <= 1'b1;
		io_addr  <= a;
		io_wdata <= v;
		io_be    <= be;
		@(posedge sys_clk);
		io_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		io_rd   <= 1'b1;
		io_addr <= a;
		@(posedge sys_clk);
		io_rd <= 1'b0;
		#1 `CHK(io_rdata, e)
	endtask : rd
	task automatic frame(input logic [47:0] a, input int len, input bit pz,
			input int gap);
		fr.delete();
		for (int i = 0; i < len; i++)
			fr.push_back(8'(xs()));
		for (int i = 0; i < 6; i++)
			fr[i] = a[(5-i)*8 +: 8];
		if (pz) begin
			fr[12] = 8'h88;
			fr[13] = 8'h08;
			fr[14] = 8'h00;
			fr[15] = 8'h01;
			fr[16] = 8'h12;
			fr[17] = 8'h34;
		end
		// Let the caller's last input updates land before predicting
		@(posedge sys_clk);
		exp_acc.push_back({a[40],
			(a[40] && group_filter_enable) ?
			tbl[hidx(a)] : other_accept});
		long_exp += (len >= (big_on ? 4491 : 1514));
		pause_exp += (pz && pause_on);
		i_phy.send(fr, gap);
		repeat (4) @(posedge sys_clk);
		`CHK(long_seen, long_exp)
		`CHK(pause_seen, pause_exp)
	endtask : frame
	task automatic conclude();
		$display("mismatches %0d of %0d checks", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude
	// ----------------------------------------------------------------
	// Clock, monitor, watchdog
	// ----------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (filter_done === 1'b1) begin
			mon_e = exp_acc.pop_front();
			`CHK({filter_multicast, filter_accept}, mon_e)
		end
		if (frame_too_long_error === 1'b1)
			long_seen++;
		if (pause_req === 1'b1)
			pause_seen++;
	end
	initial begin
		repeat (40000) @(posedge sys_clk);
		n_mismatch++;
		conclude();
	end
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{arst_n, io_wr, io_rd, io_addr, io_be, io_wdata} = '0;
		{group_filter_enable, other_accept, carrier_sense} = '0;
		{carrier_sense_err, receive_path_reset, reset_sel_net} = '0;
		{reset_sel_fifo, reset_sel_dma, pause_on, big_on, tbl} = '0;
		rng = 32'h0000_6679;
		repeat (6) @(posedge sys_clk);
		arst_n <= 1'b1;
		`CHK(ifs_bit_times, 10'h060)
		rd(8'h50, 32'h0000_0000);
		for (int w = 0; w < 4; w++)
			rd(8'(8'h60 + 2*w), 32'h0000_0000);
		wr(8'h50, 32'hFFFF_FFFF, 4'hF);
		rd(8'h50, macmh_pkg::MAC_CONFIG_MASK);
		rd(8'h70, 32'h0000_0000);
		for (int w = 0; w < 4; w++) begin
			d = xs();
			wr(8'(8'h60 + 2*w), d, 4'h3);
			tbl[w*16 +: 16] = d[15:0];
		end
		for (int w = 0; w < 4; w++)
			rd(8'(8'h60 + 2*w), {16'h0000, tbl[w*16 +: 16]});
		for (int g = 0; g < 4; g++) begin
			wr(8'h50, 32'(g), 4'hF);
			repeat (2) @(posedge sys_clk);
			`CHK(ifs_bit_times, GTAB[g])
		end
		group_filter_enable <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			da = {16'(xs()), xs()};
			da[40] = (i != 11);
			other_accept <= (i == 11);
			frame(da, 64, 1'b0, i % 3);
		end
		group_filter_enable <= 1'b0;
		frame(da | 48'h0100_0000_0000, 64, 1'b0, 0);
		frame(macmh_pkg::PAUSE_DA, 64, 1'b1, 0);
		wr(8'h50, 32'h0000_0120, 4'hF);
		pause_on = 1'b1;
		d = xs();
		@(posedge sys_clk);
		receive_path_reset <= 1'b1;
		{reset_sel_net, reset_sel_fifo, reset_sel_dma} <= d[2:0];
		@(posedge sys_clk);
		receive_path_reset <= 1'b0;
		#1 `CHK({rx_net_reset, rx_fifo_reset, rx_dma_reset}, d[2:0])
		repeat (4) @(posedge sys_clk);
		frame(macmh_pkg::PAUSE_DA, 64, 1'b1, 1);
		`CHK(pause_quanta, 16'h1234)
		carrier_sense <= 1'b1;
		for (int h = 0; h < 2; h++) begin
			repeat (2) @(posedge sys_clk);
			carrier_sense_err <= 1'b1;
			@(posedge sys_clk);
			carrier_sense_err <= 1'b0;
			#1 `CHK(carrier_loss_count_en, 1'(h))
			`CHK(tx_defer, 1'(h))
			wr(8'h50, 32'h0000_0000, 4'hF);
		end
		pause_on = 1'b0;
		for (int b = 0; b < 2; b++) begin
			wr(8'h50, 32'(b) << 9, 4'hF);
			big_on = 1'(b);
			frame(da, b ? 4490 : 1513, 1'b0, 0);
			frame(da, b ? 4491 : 1514, 1'b0, 0);
		end
		`CHK(exp_acc.size(), 0)
		conclude();
	end
endmodule : tb
